//--- design/pcpm_pkg.sv
// Package for the program counter peak monitor: offsets, widths, resets
package pcpm_pkg;
   localparam int PCPM_ADDR_W = 16;
   localparam int PCPM_DATA_W = 16;
   localparam int PCPM_PC_W = 24;
   localparam int PCPM_HI_W = 8;
   localparam int PCPM_LO_W = 16;
   // Register addresses as seen on the control port
   localparam logic [15:0] PCPM_PC_HIGH_ADDR = 16'hF460;
   localparam logic [15:0] PCPM_PC_LOW_ADDR = 16'hF461;
   localparam logic [15:0] PCPM_PC_ZERO_ADDR = 16'hF462;
   localparam logic [15:0] PCPM_FRAME_HIGH_ADDR = 16'hF463;
   localparam logic [15:0] PCPM_FRAME_LOW_ADDR = 16'hF464;
   localparam logic [15:0] PCPM_ALLTIME_HIGH_ADDR = 16'hF465;
   localparam logic [15:0] PCPM_ALLTIME_LOW_ADDR = 16'hF466;
   // Reset values
   localparam logic [15:0] PCPM_REG_RST = 16'h0000;
   localparam logic [23:0] PCPM_PC_RST = 24'h00_0000;
   localparam logic [7:0] PCPM_HI_RST = 8'h00;
   // Field positions
   localparam int PCPM_ZERO_BIT = 0;
   localparam int PCPM_HI_MSB = 23;
   localparam int PCPM_HI_LSB = 16;
   localparam logic [23:0] PCPM_PC_ONE = 24'h00_0001;
endpackage

//--- design/pcpm_peak_track.sv
// Running maximum of a 24-bit value, restarted at each boundary pulse
`timescale 1ns/1ps
`default_nettype none
module pcpm_peak_track (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic clear,
   input wire logic restart,
   // Sample and result
   input wire logic [pcpm_pkg::PCPM_PC_W-1:0] sample,
   output logic [pcpm_pkg::PCPM_PC_W-1:0] run_max
);
   import pcpm_pkg::*;

   logic [PCPM_PC_W-1:0] run_max_ff;
   logic [PCPM_PC_W-1:0] nxt_run_max;

   // Restart seeds with the current sample so no cycle is missed
   always_comb begin
      if (clear) begin
         nxt_run_max = PCPM_PC_RST;
      end else if (restart) begin
         nxt_run_max = sample;
      end else if (sample > run_max_ff) begin
         nxt_run_max = sample;
      end else begin
         nxt_run_max = run_max_ff;
      end
   end

   // Running maximum register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_max_ff <= PCPM_PC_RST;
      end else begin
         run_max_ff <= nxt_run_max;
      end
   end

   assign run_max = run_max_ff;
endmodule
`default_nettype wire

//--- design/pcpm_top.sv
// Program counter peak monitor: per-frame and all-time peaks, register port
//
// Overview of operation
// - Keep 24-bit peak of last frame
// - Frame peak low half readable at F464
// - Keep 24-bit all-time peak since start
// - All-time peak upper byte at F465
// - All-time peak low half at F466
// - Zero control clears both peaks
// - Zero bit holds counter at zero
// - Frame peak upper byte at F463
`timescale 1ns/1ps
`default_nettype none
module pcpm_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Core sequencing
   input wire logic pc_step,
   input wire logic pc_restart,
   input wire logic frame_start,
   // Register port
   input wire logic [pcpm_pkg::PCPM_ADDR_W-1:0] reg_addr,
   input wire logic [pcpm_pkg::PCPM_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pcpm_pkg::PCPM_DATA_W-1:0] reg_rdata,
   // Status
   output logic [pcpm_pkg::PCPM_PC_W-1:0] pc_value,
   output logic pc_held
);
   import pcpm_pkg::*;

   logic pc_zero_control_ff;
   logic [PCPM_PC_W-1:0] pc_ff;
   logic [PCPM_PC_W-1:0] frame_peak_ff;
   logic [PCPM_PC_W-1:0] alltime_peak_ff;
   logic [PCPM_PC_W-1:0] run_max;
   logic [PCPM_PC_W-1:0] nxt_alltime;
   logic [PCPM_DATA_W-1:0] nxt_rdata;
   logic [PCPM_DATA_W-1:0] reg_rdata_ff;
   logic [PCPM_PC_W-1:0] pc_value_ff;
   logic pc_held_ff;
   logic boundary;

   // Frame or block start comes from the core's sequencer on this clock
   assign boundary = frame_start;

   // Zero control register, bit 0 only; upper bits read as zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_zero_control_ff <= 1'b0;
      end else if (reg_wr && reg_addr == PCPM_PC_ZERO_ADDR) begin
         pc_zero_control_ff <= reg_wdata[PCPM_ZERO_BIT];
      end
   end

   // Program counter model driven by the core's step and restart pulses
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_ff <= PCPM_PC_RST;
      end else if (pc_zero_control_ff) begin
         pc_ff <= PCPM_PC_RST;
      end else if (pc_restart) begin
         pc_ff <= PCPM_PC_RST;
      end else if (pc_step) begin
         pc_ff <= pc_ff + PCPM_PC_ONE;
      end
   end

   // Running maximum within the current frame
   pcpm_peak_track u_track (
      .clk(clk),
      .rst_b(rst_b),
      .clear(pc_zero_control_ff),
      .restart(boundary),
      .sample(pc_ff),
      .run_max(run_max)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_peak_ff <= PCPM_PC_RST;
      end else if (pc_zero_control_ff) begin
         frame_peak_ff <= PCPM_PC_RST;
      end else if (boundary) begin
         frame_peak_ff <= run_max;
      end
   end

   // All-time peak only ever rises, apart from a clear
   always_comb begin
      if (boundary && run_max > alltime_peak_ff) begin
         nxt_alltime = run_max;
      end else begin
         nxt_alltime = alltime_peak_ff;
      end
   end

   // All-time peak register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alltime_peak_ff <= PCPM_PC_RST;
      end else if (pc_zero_control_ff) begin
         alltime_peak_ff <= PCPM_PC_RST;
      end else begin
         alltime_peak_ff <= nxt_alltime;
      end
   end

   // Read decode; unmapped addresses read zero, writes to peaks ignored
   always_comb begin
      nxt_rdata = PCPM_REG_RST;
      case (reg_addr)
         PCPM_PC_HIGH_ADDR: begin
            nxt_rdata = {PCPM_HI_RST, pc_ff[PCPM_HI_MSB:PCPM_HI_LSB]};
         end
         PCPM_PC_LOW_ADDR: begin
            nxt_rdata = pc_ff[PCPM_LO_W-1:0];
         end
         PCPM_PC_ZERO_ADDR: begin
            nxt_rdata = {15'h0000, pc_zero_control_ff};
         end
         PCPM_FRAME_HIGH_ADDR: begin
            nxt_rdata = {PCPM_HI_RST,
                         frame_peak_ff[PCPM_HI_MSB:PCPM_HI_LSB]};
         end
         PCPM_FRAME_LOW_ADDR: begin
            nxt_rdata = frame_peak_ff[PCPM_LO_W-1:0];
         end
         PCPM_ALLTIME_HIGH_ADDR: begin
            nxt_rdata = {PCPM_HI_RST,
                         alltime_peak_ff[PCPM_HI_MSB:PCPM_HI_LSB]};
         end
         PCPM_ALLTIME_LOW_ADDR: begin
            nxt_rdata = alltime_peak_ff[PCPM_LO_W-1:0];
         end
         default: begin
            nxt_rdata = PCPM_REG_RST;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_ff <= PCPM_REG_RST;
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end else begin
         reg_rdata_ff <= PCPM_REG_RST;
      end
   end

   // Status outputs registered so they come straight from flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_value_ff <= PCPM_PC_RST;
         pc_held_ff <= 1'b0;
      end else begin
         pc_value_ff <= pc_ff;
         pc_held_ff <= pc_zero_control_ff;
      end
   end

   assign reg_rdata = reg_rdata_ff;
   assign pc_value = pc_value_ff;
   assign pc_held = pc_held_ff;
endmodule
`default_nettype wire

//--- bench/pcpm_top_properties.sv
// Port checker for the program counter peak monitor
`timescale 1ns/1ps
`default_nettype none
module pcpm_chk import pcpm_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Stimulus
   input wire logic pc_step,
   input wire logic pc_restart,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   // Results
   input wire logic [15:0] reg_rdata,
   input wire logic [23:0] pc_value,
   input wire logic pc_held
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Four held cycles cover the lag of the copy and the counter
   sequence s_held; pc_held [*4]; endsequence
   sequence s_wz(b);
      reg_wr && reg_addr == PCPM_PC_ZERO_ADDR && reg_wdata[0] == b;
   endsequence
   property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_rsvf; reg_rd && reg_addr == PCPM_FRAME_HIGH_ADDR
      |=> reg_rdata[15:8] == 8'h00; endproperty
   a_rsvf: assert property (p_rsvf) else $error("frame rsvd set");
   property p_rsva; reg_rd && reg_addr == PCPM_ALLTIME_HIGH_ADDR
      |=> reg_rdata[15:8] == 8'h00; endproperty
   a_rsva: assert property (p_rsva) else $error("peak rsvd set");
   property p_hset; s_wz(1'b1) |-> ##[1:2] pc_held; endproperty
   a_hset: assert property (p_hset) else $error("hold not set");
   property p_hclr; s_wz(1'b0) |-> ##[1:2] !pc_held; endproperty
   a_hclr: assert property (p_hclr) else $error("hold not freed");
   property p_pc0; s_held |-> pc_value == 24'h00_0000; endproperty
   a_pc0: assert property (p_pc0) else $error("pc moved on hold");
   property p_clr; s_held ##0 reg_rd && reg_addr inside
      {[PCPM_FRAME_HIGH_ADDR:PCPM_ALLTIME_LOW_ADDR]}
      |=> reg_rdata == 16'h0000; endproperty
   a_clr: assert property (p_clr) else $error("peak not cleared");
   property p_step; pc_step && !pc_restart && !pc_held ##1 !pc_held
      ##1 !pc_held |-> pc_value == $past(pc_value) + PCPM_PC_ONE;
   endproperty
   a_step: assert property (p_step) else $error("pc not stepped");
endmodule
bind pcpm_top pcpm_chk i_pcpm_chk (.clk, .rst_b, .pc_step, .pc_restart,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pc_value, .pc_held);
`default_nettype wire

//--- bench/tb_pcpm_top.sv
// Bench for the program counter peak monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module tb_pcpm_top;
   import pcpm_pkg::*;
   logic clk = 0, rst_b = 0, pc_step = 0, pc_restart = 0, frame_start = 0;
   logic reg_wr = 0, reg_rd = 0, pc_held;
   logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [23:0] pc_value;
   int failures = 0, compares = 0;
   pcpm_top i_pcpm_top (.clk, .rst_b, .pc_step, .pc_restart, .frame_start,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pc_value, .pc_held);
   // 8 ns clock
   initial forever #4 clk = ~clk;
   // Bus cycles; a gap cycle keeps strobes from being assigned twice
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("rdata", e, reg_rdata)
      @(posedge clk);
   endtask
   task automatic peaks(input logic [23:0] f, input logic [23:0] m);
      rd(PCPM_FRAME_HIGH_ADDR, {8'h00, f[23:16]});
      rd(PCPM_FRAME_LOW_ADDR, f[15:0]);
      rd(PCPM_ALLTIME_HIGH_ADDR, {8'h00, m[23:16]});
      rd(PCPM_ALLTIME_LOW_ADDR, m[15:0]);
   endtask
   // Core sequencing
   task automatic step(input int n);
      pc_step <= 1'b1;
      repeat (n) @(posedge clk);
      pc_step <= 1'b0;
      @(posedge clk);
   endtask
   task automatic frame();
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // Counter copy and hold flag, looked at 1 ns after the edge that set them
   task automatic cpc(input logic [23:0] e, input logic h);
      #1;
      `CHK("pc", e, pc_value)
      `CHK("held", h, pc_held)
      @(posedge clk);
   endtask
   task automatic final_report();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog well past the longest count
   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      peaks(24'h00_0000, 24'h00_0000);
      wr(PCPM_FRAME_LOW_ADDR, 16'hFFFF);
      rd(16'hF467, 16'h0000);
      rd(PCPM_FRAME_LOW_ADDR, 16'h0000);
      $display("reset test done");
      // Count past 16 bits so the upper byte is used
      step(24'h01_0005);
      cpc(24'h01_0005, 1'b0);
      rd(PCPM_PC_HIGH_ADDR, 16'h0001);
      rd(PCPM_PC_LOW_ADDR, 16'h0005);
      frame();
      peaks(24'h01_0005, 24'h01_0005);
      pc_restart <= 1'b1;
      @(posedge clk);
      pc_restart <= 1'b0;
      frame();
      step(3);
      frame();
      peaks(24'h00_0003, 24'h01_0005);
      $display("peak test done");
      // Steps and boundaries while held change nothing
      wr(PCPM_PC_ZERO_ADDR, 16'h0001);
      step(4);
      frame();
      cpc(24'h00_0000, 1'b1);
      rd(PCPM_PC_ZERO_ADDR, 16'h0001);
      rd(PCPM_PC_LOW_ADDR, 16'h0000);
      peaks(24'h00_0000, 24'h00_0000);
      $display("hold test done");
      wr(PCPM_PC_ZERO_ADDR, 16'h0000);
      step(2);
      cpc(24'h00_0002, 1'b0);
      frame();
      peaks(24'h00_0002, 24'h00_0002);
      $display("release test done");
      final_report();
   end
endmodule
`default_nettype wire
